// ===== inc/hsp_pkg.sv
// Shared constants for the host bus slave port.
package hsp_pkg;
    // Bus geometry.
    localparam int ADDR_W        = 18;
    localparam int DATA_W        = 32;
    localparam int LANES         = 4;
    localparam int BURST_BEATS   = 4;
    // Transfer size encodings driven by the master.
    localparam logic [1:0] SIZE_WORD = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_HALF = 2'h2;
    localparam logic [1:0] SIZE_RSVD = 2'h3;
    // Data bus width select encodings.
    localparam logic [1:0] WIDTH_8   = 2'h0;
    localparam logic [1:0] WIDTH_16  = 2'h1;
    localparam logic [1:0] WIDTH_32  = 2'h2;
    // Active byte lanes per bus width.
    localparam logic [3:0] LANES_8   = 4'h1;
    localparam logic [3:0] LANES_16  = 4'h3;
    localparam logic [3:0] LANES_32  = 4'hF;
    // Byte enables per size.
    localparam logic [3:0] BE_BYTE   = 4'h1;
    localparam logic [3:0] BE_HALF_LO = 4'h3;
    localparam logic [3:0] BE_HALF_HI = 4'hC;
    localparam logic [3:0] BE_WORD   = 4'hF;
    // Idle and reset levels, and the parity sense.
    localparam logic [3:0] OE_OFF    = 4'hF;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [17:0] ADDR_RST = 18'h0_0000;
    localparam logic       PARITY_ODD = 1'b1;
endpackage

// ===== verilog/hsp_lane_parity.sv
// Per-byte-lane parity generator.
`timescale 1ns/1ns
module hsp_lane_parity #(
    parameter int   LANES = 4,
    parameter logic ODD   = 1'b1
) (
    // Data in.
    input  wire logic [8*LANES-1:0] i_data,
    // One parity bit per lane.
    output logic      [LANES-1:0]   o_parity
);
    initial begin
        if (LANES < 1) begin
            $error("hsp_lane_parity: LANES must be at least 1");
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign o_parity[g] = (^i_data[8*g+7:8*g]) ^ ODD;  // [RULE10]
    end
endmodule // hsp_lane_parity

// ===== verilog/hsp_host_port.sv
// Synchronous slave side of the host processor port.
`timescale 1ns/1ns
// Functional notes
// RULE1 - Master drives low eighteen address bits; only those are decoded.
// RULE2 - Burst indicator low during a burst, high for a single transfer.
// RULE3 - Burst-data-in-progress requests next beat; early negation aborts the burst.
// RULE4 - Size field: 01 byte, 10 half-word, 00 word; transfer sized accordingly.
// RULE5 - Acknowledge low once write data accepted or read data driven.
// RULE6 - Internal bus error drives transfer-error acknowledge low.
// RULE7 - Port may request retry; master releases bus and reissues later.
// RULE8 - All signalling synchronous to rising edge of host bus clock.
// RULE9 - Data width 8, 16 or 32; master drives writes, port drives reads.
// RULE10 - One parity line per byte lane, lane 0 covers bits 7:0.
// RULE11 - At most one response per beat, one cycle each, all high idle.
module hsp_host_port #(
    parameter int BURST_BEATS = hsp_pkg::BURST_BEATS
) (
    // Clock is the host bus clock; reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Address phase from the bus master.
    input  wire logic        i_transfer_start_n,
    input  wire logic        i_read_not_write,
    input  wire logic [17:0] i_addr,
    input  wire logic [1:0]  i_transfer_size,
    input  wire logic        i_burst_indicator_n,
    input  wire logic        i_burst_data_in_progress,
    // Data and parity pins, split into input, output and enable.
    input  wire logic [31:0] i_data,
    output logic      [31:0] o_data,
    output logic      [3:0]  o_data_oe_n,
    input  wire logic [3:0]  i_data_parity,
    output logic      [3:0]  o_data_parity,
    output logic      [3:0]  o_data_parity_oe_n,
    // Responses to the master.
    output logic             o_transfer_ack_n,
    output logic             o_transfer_error_ack_n,
    output logic             o_retry_request_n,
    // Static configuration.
    input  wire logic [1:0]  i_bus_width,
    // Internal system bus.
    output logic             o_sys_req,
    output logic             o_sys_write,
    output logic      [17:0] o_sys_addr,
    output logic      [3:0]  o_sys_be,
    output logic      [31:0] o_sys_wdata,
    input  wire logic [31:0] i_sys_rdata,
    input  wire logic        i_sys_ready,
    input  wire logic        i_sys_error,
    input  wire logic        i_sys_retry,
    // Write parity mismatch, one cycle.
    output logic             o_parity_error
);
    initial begin
        if (BURST_BEATS < 1 || BURST_BEATS > 4) begin
            $error("hsp_host_port: BURST_BEATS must lie in 1..4");
        end
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_RESP = 2'b10
    } hsp_state_t;

    hsp_state_t  state_reg, state_next;
    logic [17:0] addr_reg;
    logic [1:0]  size_reg;
    logic        write_reg;
    logic        burst_reg;
    logic [1:0]  beat_reg;
    logic        req_reg;
    logic [3:0]  be_reg;
    logic [31:0] wdata_reg;
    logic        ack_n_reg, tea_n_reg, rty_n_reg;
    logic [31:0] dout_reg;
    logic [3:0]  oe_n_reg, par_reg;
    logic        perr_reg;

    // The host bus clock is i_clk itself, so pins need no synchroniser. [RULE8]
    wire         start      = (state_reg == ST_IDLE) && !i_transfer_start_n;
    wire         resp_seen  = req_reg && (i_sys_ready || i_sys_error || i_sys_retry);
    // Error beats retry and retry beats ready, so only one response is given. [RULE11]
    wire         take_err   = req_reg && i_sys_error;                          // [RULE6]
    wire         take_rty   = req_reg && !i_sys_error && i_sys_retry;          // [RULE7]
    wire         take_ack   = req_reg && !i_sys_error && !i_sys_retry && i_sys_ready;
    // A reserved size never reaches the system bus and is answered with an error.
    wire         bad_size   = (i_transfer_size == hsp_pkg::SIZE_RSVD);
    wire [3:0]   lane_mask  = (i_bus_width == hsp_pkg::WIDTH_8)  ? hsp_pkg::LANES_8 :
                              (i_bus_width == hsp_pkg::WIDTH_16) ? hsp_pkg::LANES_16 :
                                                                   hsp_pkg::LANES_32;
    // Narrow buses carry the addressed bytes on the low lanes. [RULE9]
    wire [1:0]   lane_off   = (i_bus_width == hsp_pkg::WIDTH_8)  ? addr_reg[1:0] :
                              (i_bus_width == hsp_pkg::WIDTH_16) ? {addr_reg[1], 1'b0} :
                                                                   2'b00;
    wire [4:0]   bit_off    = {lane_off, 3'b000};
    wire [31:0]  rd_aligned = i_sys_rdata >> bit_off;
    wire [31:0]  wr_aligned = i_data << bit_off;
    wire [3:0]   be_new     = (i_transfer_size == hsp_pkg::SIZE_BYTE) ?
                                  (hsp_pkg::BE_BYTE << i_addr[1:0]) :          // [RULE4]
                              (i_transfer_size == hsp_pkg::SIZE_HALF) ?
                                  (i_addr[1] ? hsp_pkg::BE_HALF_HI : hsp_pkg::BE_HALF_LO) :
                                  hsp_pkg::BE_WORD;
    wire [3:0]   rd_par, wr_par;
    wire         more_beats = burst_reg && i_burst_data_in_progress &&           // [RULE3]
                              (beat_reg != 2'(BURST_BEATS - 1)) && !ack_n_reg;
    wire [3:0]   wr_par_bad = (wr_par ^ i_data_parity) & lane_mask;
    // Write data is sampled the cycle after the address or after the previous beat.
    wire         wr_sample  = write_reg && (state_reg == ST_REQ) && !req_reg;

    hsp_lane_parity #(.LANES(hsp_pkg::LANES), .ODD(hsp_pkg::PARITY_ODD)) u_rd_par (
        .i_data   (rd_aligned),
        .o_parity (rd_par)
    );
    hsp_lane_parity #(.LANES(hsp_pkg::LANES), .ODD(hsp_pkg::PARITY_ODD)) u_wr_par (
        .i_data   (i_data),
        .o_parity (wr_par)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = bad_size ? ST_RESP : ST_REQ;
                end
            end
            ST_REQ: begin
                if (resp_seen) begin
                    state_next = ST_RESP;
                end
            end
            ST_RESP: begin
                state_next = more_beats ? ST_REQ : ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Address phase capture and burst stepping.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            addr_reg  <= hsp_pkg::ADDR_RST;
            size_reg  <= hsp_pkg::SIZE_WORD;
            write_reg <= 1'b0;
            burst_reg <= 1'b0;
            beat_reg  <= 2'b00;
            be_reg    <= hsp_pkg::BE_WORD;
        end else begin
            state_reg <= state_next;
            if (start) begin
                addr_reg  <= i_addr;                                 // [RULE1]
                size_reg  <= i_transfer_size;                        // [RULE4]
                write_reg <= !i_read_not_write;
                burst_reg <= !i_burst_indicator_n;                   // [RULE2]
                beat_reg  <= 2'b00;
                be_reg    <= be_new;
            end else if (state_reg == ST_RESP && more_beats) begin
                // Bursts wrap on a four-word line.
                addr_reg[3:2] <= addr_reg[3:2] + 2'b01;
                beat_reg      <= beat_reg + 2'b01;
            end
        end
    end

    // Internal system bus request held until any response.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_reg   <= 1'b0;
            wdata_reg <= hsp_pkg::DATA_RST;
            perr_reg  <= 1'b0;
        end else begin
            perr_reg <= wr_sample && (wr_par_bad != 4'h0);           // [RULE10]
            if (wr_sample) begin
                wdata_reg <= wr_aligned;                             // [RULE9]
            end
            if (resp_seen) begin
                req_reg <= 1'b0;
            end else if (state_reg == ST_REQ && (!write_reg || wr_sample)) begin
                req_reg <= !wr_sample || write_reg;
            end
        end
    end

    // Response strobes and read data drive.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_n_reg <= 1'b1;
            tea_n_reg <= 1'b1;
            rty_n_reg <= 1'b1;
            dout_reg  <= hsp_pkg::DATA_RST;
            oe_n_reg  <= hsp_pkg::OE_OFF;
            par_reg   <= 4'h0;
        end else begin
            ack_n_reg <= !take_ack;                                  // [RULE5] [RULE11]
            tea_n_reg <= !(take_err || (start && bad_size));         // [RULE6] [RULE11]
            rty_n_reg <= !take_rty;                                  // [RULE7] [RULE11]
            if (take_ack && !write_reg) begin
                dout_reg <= rd_aligned;
                par_reg  <= rd_par;                                  // [RULE10]
                oe_n_reg <= ~lane_mask;                              // [RULE9]
            end else begin
                oe_n_reg <= hsp_pkg::OE_OFF;
            end
        end
    end

    assign o_data                 = dout_reg;
    assign o_data_oe_n            = oe_n_reg;
    assign o_data_parity          = par_reg;
    assign o_data_parity_oe_n     = oe_n_reg;
    assign o_transfer_ack_n       = ack_n_reg;
    assign o_transfer_error_ack_n = tea_n_reg;
    assign o_retry_request_n      = rty_n_reg;
    assign o_sys_req              = req_reg;
    assign o_sys_write            = write_reg;
    assign o_sys_addr             = addr_reg;
    assign o_sys_be               = be_reg;
    assign o_sys_wdata            = wdata_reg;
    assign o_parity_error         = perr_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_ONE_RESP: assert property (                                  // [RULE11]
        (o_transfer_ack_n + o_transfer_error_ack_n + o_retry_request_n) >= 2'd2)
        else $error("more than one response strobe low");
    AST_ACK_PULSE: assert property (                                 // [RULE11]
        !o_transfer_ack_n |=> o_transfer_ack_n)
        else $error("acknowledge held longer than one cycle");
    AST_ACK_CAUSE: assert property (                                 // [RULE5]
        (req_reg && i_sys_ready && !i_sys_error && !i_sys_retry) |=> !o_transfer_ack_n)
        else $error("system ready not acknowledged next cycle");
    AST_TEA_CAUSE: assert property (                                 // [RULE6]
        (req_reg && i_sys_error) |=> (!o_transfer_error_ack_n && o_transfer_ack_n))
        else $error("system error not reported");
    AST_RETRY_CAUSE: assert property (                               // [RULE7]
        (req_reg && i_sys_retry && !i_sys_error) |=> !o_retry_request_n)
        else $error("system retry not passed on");
    AST_READ_DRIVE: assert property (                                // [RULE9]
        (!o_transfer_ack_n && !write_reg) |-> (o_data_oe_n == ~lane_mask))
        else $error("read data not driven with acknowledge");
    AST_NO_DRIVE: assert property (                                  // [RULE9]
        (o_transfer_ack_n || write_reg) |-> (o_data_oe_n == hsp_pkg::OE_OFF))
        else $error("data bus driven outside a read acknowledge");
    AST_PARITY: assert property (                                    // [RULE10]
        !o_data_oe_n[0] |-> (o_data_parity[0] == ((^o_data[7:0]) ^ hsp_pkg::PARITY_ODD)))
        else $error("lane 0 parity wrong");
    AST_BYTE_BE: assert property (                                   // [RULE4]
        (o_sys_req && size_reg == hsp_pkg::SIZE_BYTE) |-> $onehot(o_sys_be))
        else $error("byte transfer with wrong byte enables");
    AST_BURST_ABORT: assert property (                               // [RULE3]
        (state_reg == ST_RESP && !i_burst_data_in_progress) |=> state_reg == ST_IDLE)
        else $error("burst continued after abort");

    COV_READ: cover property (!o_transfer_ack_n && !write_reg);
    COV_WRITE: cover property (!o_transfer_ack_n && write_reg);
    COV_BURST4: cover property (!o_transfer_ack_n && burst_reg && beat_reg == 2'b11);
    COV_TEA: cover property (!o_transfer_error_ack_n);
endmodule // hsp_host_port

// ===== testbench/hsp_host_model.sv
// Bus master model that drives the host side of the port.
`timescale 1ns/1ns
module hsp_host_model (
    // Clock.
    input  wire logic        i_clk,
    // Requests toward the port.
    output logic             o_start_n,
    output logic             o_rnw,
    output logic      [17:0] o_addr,
    output logic      [1:0]  o_size,
    output logic             o_burst_n,
    output logic             o_bdip,
    output logic      [31:0] o_data,
    output logic      [3:0]  o_par,
    // Pins driven by the port.
    input  wire logic [31:0] i_data,
    input  wire logic [3:0]  i_par,
    input  wire logic [3:0]  i_oe_n,
    input  wire logic        i_ack_n,
    input  wire logic        i_tea_n,
    input  wire logic        i_rty_n
);
    logic [31:0] wd = 32'h0;
    logic [3:0]  wp = 4'h0;
    logic [31:0] rdata;
    logic [3:0]  rpar;
    logic [3:0]  roe;
    int          rsp;
    int          strobes;
    initial begin
        o_start_n = 1'b1;
        o_rnw = 1'b0;
        o_addr = 18'h0;
        o_size = 2'h0;
        o_burst_n = 1'b1;
        o_bdip = 1'b0;
    end
    // A lane the port does not drive on a read shows the inverse of the transfer data, so stale data fails.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_data[8*k+:8] = !i_oe_n[k] ? i_data[8*k+:8] : (o_rnw ? ~wd[8*k+:8] : wd[8*k+:8]);
            o_par[k] = !i_oe_n[k] ? i_par[k] : (o_rnw ? ~wp[k] : wp[k]);
        end
    end
    task automatic xfer(input logic rw, input logic [17:0] a, input logic [1:0] sz,
                        input logic [31:0] d, input logic [3:0] p, input int beats);
        strobes = 0;
        @(negedge i_clk);
        o_start_n <= 1'b0;
        o_rnw <= rw;
        o_addr <= a;
        o_size <= sz;
        o_burst_n <= (beats == 1);
        o_bdip <= (beats > 1);
        wd <= d;
        wp <= p;
        @(negedge i_clk);
        o_start_n <= 1'b1;
        for (int n = 0; n < beats; n++) begin
            if (n == beats - 1) o_bdip <= 1'b0;
            rsp = 3;
            for (int t = 0; t < 40 && rsp == 3; t++) begin
                if (i_ack_n === 1'b0) rsp = 0;
                else if (i_tea_n === 1'b0) rsp = 1;
                else if (i_rty_n === 1'b0) rsp = 2;
                strobes += int'(i_ack_n !== 1'b1) + int'(i_tea_n !== 1'b1) + int'(i_rty_n !== 1'b1);
                rdata = i_data;
                rpar = i_par;
                roe = i_oe_n;
                @(negedge i_clk);
            end
            if (rsp != 0) break;
        end
        strobes += int'(i_ack_n !== 1'b1) + int'(i_tea_n !== 1'b1) + int'(i_rty_n !== 1'b1);
    endtask
endmodule // hsp_host_model

// ===== testbench/test_host_bus_slave_port.sv
// Self-checking bench for the host bus slave port.
`timescale 1ns/1ns
module test_host_bus_slave_port;
    typedef struct {
        logic rw; logic [17:0] a; logic [1:0] sz; logic [1:0] w;
        logic [31:0] d; logic [31:0] e; logic [3:0] be; int mode; int rsp;
    } hsp_tb_row_t;
    hsp_tb_row_t rows [8] = '{
        '{1'b1, 18'h00010, 2'h0, 2'h2, 32'h89AB_CDEF, 32'h89AB_CDEF, 4'hF, 0, 0},
        '{1'b1, 18'h00002, 2'h1, 2'h0, 32'h1122_3344, 32'h0000_0022, 4'h4, 0, 0},
        '{1'b1, 18'h00002, 2'h2, 2'h1, 32'hA5C3_0F1E, 32'h0000_A5C3, 4'hC, 0, 0},
        '{1'b0, 18'h3FFFC, 2'h0, 2'h2, 32'hDEAD_BEEF, 32'hDEAD_BEEF, 4'hF, 0, 0},
        '{1'b0, 18'h00001, 2'h1, 2'h3, 32'h0000_5A00, 32'h0000_5A00, 4'h2, 0, 0},
        '{1'b1, 18'h00100, 2'h0, 2'h2, 32'h0F0F_0F0F, 32'h0F0F_0F0F, 4'hF, 1, 1},
        '{1'b1, 18'h00104, 2'h0, 2'h2, 32'h7777_7777, 32'h7777_7777, 4'hF, 2, 2},
        '{1'b1, 18'h00108, 2'h3, 2'h2, 32'h1234_5678, 32'h1234_5678, 4'hF, 0, 1}
    };
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        start_n, rnw, burst_n, bdip, ack_n, tea_n, rty_n, sys_req, sys_wr, perr;
    logic [17:0] addr, sys_addr, la;
    logic [1:0]  size;
    logic [1:0]  bus_width = 2'h2;
    logic [31:0] hdata, ddata, sys_wdata, lwd;
    logic [31:0] sys_rdata = 32'h0;
    logic [3:0]  hpar, dpar, oe_n, poe_n, sys_be, lbe, lpoe;
    logic        sys_ready = 1'b0, sys_error = 1'b0, sys_retry = 1'b0, lw, answered = 1'b0;
    logic        perr_seen = 1'b0;
    logic [17:0] aq [$];
    int          sys_mode = 0, sys_delay = 0, wait_cnt = 0, nreq = 0;
    int          mismatches = 0, check_count = 0;
    always #10 i_clk = ~i_clk;
    hsp_host_model m_u (.i_clk(i_clk), .o_start_n(start_n), .o_rnw(rnw), .o_addr(addr),
        .o_size(size), .o_burst_n(burst_n), .o_bdip(bdip), .o_data(hdata), .o_par(hpar),
        .i_data(ddata), .i_par(dpar), .i_oe_n(oe_n), .i_ack_n(ack_n), .i_tea_n(tea_n),
        .i_rty_n(rty_n));
    hsp_host_port dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_transfer_start_n(start_n),
        .i_read_not_write(rnw), .i_addr(addr), .i_transfer_size(size),
        .i_burst_indicator_n(burst_n), .i_burst_data_in_progress(bdip), .i_data(hdata),
        .o_data(ddata), .o_data_oe_n(oe_n), .i_data_parity(hpar), .o_data_parity(dpar),
        .o_data_parity_oe_n(poe_n), .o_transfer_ack_n(ack_n), .o_transfer_error_ack_n(tea_n),
        .o_retry_request_n(rty_n), .i_bus_width(bus_width), .o_sys_req(sys_req),
        .o_sys_write(sys_wr), .o_sys_addr(sys_addr), .o_sys_be(sys_be),
        .o_sys_wdata(sys_wdata), .i_sys_rdata(sys_rdata), .i_sys_ready(sys_ready),
        .i_sys_error(sys_error), .i_sys_retry(sys_retry), .o_parity_error(perr));
    // Internal bus responder: answers once per request after sys_delay cycles.
    always @(negedge i_clk) begin
        sys_ready <= 1'b0;
        sys_error <= 1'b0;
        sys_retry <= 1'b0;
        if (perr === 1'b1) perr_seen = 1'b1;
        if (ack_n === 1'b0) lpoe = poe_n;
        if (sys_req === 1'b1 && !answered) begin
            if (wait_cnt >= sys_delay) begin
                sys_ready <= (sys_mode == 0);
                sys_error <= (sys_mode == 1);
                sys_retry <= (sys_mode == 2);
                answered <= 1'b1;
                wait_cnt <= 0;
                nreq++;
                la = sys_addr;
                lbe = sys_be;
                lwd = sys_wdata;
                lw = sys_wr;
                aq.push_back(sys_addr);
            end else wait_cnt <= wait_cnt + 1;
        end else if (sys_req !== 1'b1) answered <= 1'b0;
    end
    function automatic logic [3:0] par(input logic [31:0] d);
        for (int k = 0; k < 4; k++) par[k] = ~^d[8*k+:8];
    endfunction
    function automatic logic [31:0] bmask(input logic [3:0] be);
        for (int k = 0; k < 4; k++) bmask[8*k+:8] = {8{be[k]}};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic run(input logic rw, input logic [17:0] a, input logic [1:0] sz,
                       input logic [31:0] d, input logic [3:0] p, input int beats);
        nreq = 0;
        perr_seen = 1'b0;
        aq.delete();
        m_u.xfer(rw, a, sz, d, p, beats);
        // A missing response would leave every later expectation meaningless.
        if (m_u.rsp == 3) begin
            chk("response", 32'h0, 32'h3);
            conclude();
        end
    endtask
    initial begin
        logic [3:0] ln;
        repeat (5) @(negedge i_clk);
        chk("reset idle", {3'h7, 8'hFF, 1'b0, 4'hF}, {ack_n, tea_n, rty_n, oe_n, poe_n, sys_req, sys_be});
        chk("reset data", 32'h0, ddata);
        chk("reset parity", 32'h0, dpar);
        i_rst_n <= 1'b1;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            bus_width <= rows[i].w;
            sys_rdata <= rows[i].d;
            sys_mode = rows[i].mode;
            sys_delay = i % 3;
            ln = (rows[i].w == 2'h0) ? 4'h1 : (rows[i].w == 2'h1) ? 4'h3 : 4'hF;
            run(rows[i].rw, rows[i].a, rows[i].sz, rows[i].d, par(rows[i].d), 1);
            chk("response", rows[i].rsp, m_u.rsp);
            chk("strobes", 1, m_u.strobes);
            chk("requests", (rows[i].sz == 2'h3) ? 0 : 1, nreq);
            chk("parity error", 0, perr_seen);
            if (nreq > 0) begin
                chk("sys addr", rows[i].a, la);
                chk("sys be", rows[i].be, lbe);
                chk("sys write", !rows[i].rw, lw);
            end
            if (rows[i].rw && rows[i].rsp == 0) begin
                chk("read data", rows[i].e & bmask(ln), m_u.rdata & bmask(ln));
                chk("read oe", 4'(~ln), m_u.roe);
                chk("read parity oe", 4'(~ln), lpoe);
                chk("read parity", par(rows[i].e) & ln, m_u.rpar & ln);
            end
            if (!rows[i].rw) chk("sys wdata", rows[i].e & bmask(rows[i].be), lwd & bmask(rows[i].be));
            chk("idle oe", 8'hFF, {oe_n, poe_n});
            // The master must reissue a retried cycle unchanged.
            if (rows[i].rsp == 2) begin
                sys_mode = 0;
                run(rows[i].rw, rows[i].a, rows[i].sz, rows[i].d, par(rows[i].d), 1);
                chk("reissue response", 0, m_u.rsp);
                chk("reissue addr", rows[i].a, la);
            end
            $display("test row %0d done", i);
        end
        bus_width <= 2'h2;
        sys_mode = 0;
        sys_delay = 0;
        run(1'b1, 18'h0000C, 2'h0, 32'h1357_9BDF, 4'h0, 3);
        chk("burst beats", 3, nreq);
        chk("burst beat 1", 18'h00000, aq[1]);
        chk("burst beat 2", 18'h00004, aq[2]);
        chk("burst strobes", 3, m_u.strobes);
        run(1'b1, 18'h00004, 2'h0, 32'h0, 4'h0, 4);
        chk("full burst beats", 4, nreq);
        chk("full burst wrap", 18'h00000, aq[3]);
        chk("full burst strobes", 4, m_u.strobes);
        $display("test burst done");
        run(1'b0, 18'h00020, 2'h0, 32'hCAFE_F00D, ~par(32'hCAFE_F00D), 1);
        chk("bad parity flag", 1, perr_seen);
        chk("bad parity ack", 0, m_u.rsp);
        $display("test parity done");
        sys_rdata <= 32'h2468_ACE0;
        i_rst_n <= 1'b0;
        @(negedge i_clk);
        chk("mid reset idle", {3'h7, 8'hFF, 1'b0}, {ack_n, tea_n, rty_n, oe_n, poe_n, sys_req});
        i_rst_n <= 1'b1;
        run(1'b1, 18'h00030, 2'h0, 32'h2468_ACE0, 4'h0, 1);
        chk("after reset response", 0, m_u.rsp);
        chk("after reset data", 32'h2468_ACE0, m_u.rdata);
        $display("test mid reset done");
        conclude();
    end
endmodule // test_host_bus_slave_port
